// >>> rtl/flag_logic_defines.vh
// constants for the flag register block
`ifndef FLAG_LOGIC_DEFINES_VH
`define FLAG_LOGIC_DEFINES_VH
// apb register byte offsets
`define OFS_FLAGS      8'h00
`define OFS_CTRL       8'h04
`define OFS_EVT_STAT   8'h08
`define OFS_EVT_MASK   8'h0C
`define OFS_SAVED_IMG  8'h10
// flag bit positions
`define BIT_CARRY      0
`define BIT_FIXED_ONE  1
`define BIT_PARITY     2
`define BIT_HALF_CARRY 4
`define BIT_ZERO       6
`define BIT_SIGN       7
`define BIT_STEP       8
`define BIT_INT_EN     9
`define BIT_DIR        10
`define BIT_OVERFLOW   11
`define BIT_IO_PRIVILEGE_LEVEL_LO    12
`define BIT_IO_PRIVILEGE_LEVEL_HI    13
// implemented bits, arithmetic bits, reset image
`define FLAGS_IMPL     32'h0000_3FD5
`define FLAGS_ARITH    32'h0000_08D5
`define FLAGS_RESET    32'h0000_0002
`define FLAGS_ONE      32'h0000_0002
// control fields
`define CTRL_CPL_LO    0
`define CTRL_CPL_HI    1
`define CTRL_PMODE     2
`define CTRL_BITMAP    3
`define CTRL_RESET     32'h0000_0000
// event bits
`define EVT_IO_FAULT   0
`define EVT_IO_BITMAP  1
`define EVT_STEP_TRAP  2
`define EVT_BRK_TRAP   3
`define EVT_INT_TAKEN  4
`define EVT_WIDTH      5
// operand width codes
`define WID_BYTE       2'b00
`define WID_WORD       2'b01
`define WID_DWORD      2'b10
`endif

// >>> rtl/arith_flag_unit.v
// adder with status flag generation for byte, word and dword operands
`timescale 1ns/1ps
`include "flag_logic_defines.vh"
module arith_flag_unit (
   // operation
   input  wire        sub,
   input  wire [1:0]  width,
   input  wire [31:0] opa,
   input  wire [31:0] opb,
   // answer
   output reg  [31:0] result,
   output reg         carry_out_flag,
   output reg         low_byte_parity_flag,
   output reg         half_carry_flag,
   output reg         zero_flag,
   output reg         sign_flag,
   output reg         signed_overflow_flag
);
   wire [31:0] opb_x = sub ? ~opb : opb;
   wire        cin   = sub;
   wire [8:0]  s8    = {1'b0, opa[7:0]} + {1'b0, opb_x[7:0]} + {8'h00, cin};
   wire [16:0] s16   = {1'b0, opa[15:0]} + {1'b0, opb_x[15:0]}
                       + {16'h0000, cin};
   wire [32:0] s32   = {1'b0, opa} + {1'b0, opb_x} + {32'h0000_0000, cin};
   reg         cout;
   reg         cmsb;
   always @* begin
      result = s32[31:0];
      cout   = s32[32];
      cmsb   = opa[31] ^ opb_x[31] ^ s32[31];
      case (width)
         `WID_BYTE: begin
            result = {24'h00_0000, s8[7:0]};
            cout   = s8[8];
            cmsb   = opa[7] ^ opb_x[7] ^ s8[7];
         end
         `WID_WORD: begin
            result = {16'h0000, s16[15:0]};
            cout   = s16[16];
            cmsb   = opa[15] ^ opb_x[15] ^ s16[15];
         end
         default: begin
            result = s32[31:0];
         end
      endcase
      // RL12: carry or borrow
      carry_out_flag       = sub ? ~cout : cout;
      // RL4: carry in vs out
      signed_overflow_flag = cmsb ^ cout;
      // RL8: msb of width
      sign_flag            = (width == `WID_BYTE) ? result[7] :
                             (width == `WID_WORD) ? result[15] : result[31];
      // RL9: all zero
      zero_flag            = (result == 32'h0000_0000);
      // RL10: bit 3 carry
      half_carry_flag      = opa[4] ^ opb[4] ^ result[4];
      // RL11: even low byte
      low_byte_parity_flag = ~^result[7:0];
   end
endmodule

// >>> rtl/io_priv_check.v
// privilege comparisons for i/o access and flag pops
`timescale 1ns/1ps
module io_priv_check (
   // privilege state
   input  wire [1:0] current_privilege_level,
   input  wire [1:0] io_privilege_level,
   input  wire       prot_mode,
   input  wire       bitmap_en,
   // decisions
   output wire       io_ok,
   output wire       io_fault,
   output wire       io_bitmap,
   output wire       int_en_write_ok,
   output wire       io_privilege_level_write_ok
);
   // real mode runs at level 0, so the field gates nothing there
   wire cpl_ok = ~prot_mode |
                 (current_privilege_level <= io_privilege_level);
   // RL1: i/o gating
   assign io_ok     = cpl_ok;
   assign io_fault  = ~cpl_ok & ~bitmap_en;
   assign io_bitmap = ~cpl_ok & bitmap_en;
   // RL3: int enable gate
   assign int_en_write_ok = cpl_ok;
   // RL2: level zero only
   assign io_privilege_level_write_ok   = ~prot_mode |
                            (current_privilege_level == 2'b00);
endmodule

// >>> rtl/cpu_flag_state_logic.v
// flag register, flag generation and privilege control of the core
// Functional notes
// RL1: i/o instructions pass only when the current level is at most the field, else fault 13 or bitmap check.
// RL2: pop-flags and interrupt-return change the field only at level 0, a task switch always reloads it.
// RL3: a pop changes the interrupt-enable bit only when the current level is at most the field.
// RL4: overflow is set when carry into the sign bit differs from carry out of it.
// RL5: string index registers step up when direction is 0 and down when it is 1.
// RL6: maskable interrupt requests are recognised only while interrupt-enable is 1.
// RL7: single-step set traps after the next instruction, else traps only on breakpoint matches.
// RL8: sign copies the result msb of the operand width.
// RL9: zero is set when every result bit is 0.
// RL10: half-carry follows carry out of or borrow into bit 3 for every width.
// RL11: parity is set when the low result byte holds an even count of ones.
// RL12: carry follows carry out of or borrow into the result msb.
// RL13: a stored flag image holds 1 in bit 1 and 0 in bits 3, 5, 15 and 19 to 31.
`timescale 1ns/1ps
`include "flag_logic_defines.vh"
module cpu_flag_state_logic (
   // clock and reset
   input  wire        mclk,
   input  wire        arst_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // arithmetic operation
   input  wire        alu_valid,
   input  wire        alu_sub,
   input  wire [1:0]  alu_width,
   input  wire [31:0] alu_opa,
   input  wire [31:0] alu_opb,
   output reg  [31:0] alu_result,
   // flag pops and task switch
   input  wire        pop_flags_instruction,
   input  wire        interrupt_return_instruction,
   input  wire [31:0] pop_image,
   input  wire        task_switch,
   input  wire [31:0] task_state_record,
   // flag stores
   input  wire        push_flags_instruction,
   input  wire        interrupt_entry,
   output reg  [31:0] stored_image,
   // i/o instruction check
   input  wire        io_req,
   output reg         io_grant,
   output reg         io_fault13,
   output reg         io_bitmap_check,
   // string index stepping
   input  wire        string_step,
   input  wire [2:0]  string_size,
   input  wire [31:0] source_index_in,
   input  wire [31:0] destination_index_in,
   output reg  [31:0] source_index_register,
   output reg  [31:0] destination_index_register,
   // interrupt and trap
   input  wire        maskable_interrupt_request,
   input  wire        insn_done,
   input  wire        breakpoint_match,
   output reg         interrupt_recognised,
   output reg         debug_trap,
   // flag state view and interrupt
   output reg  [31:0] processor_flags,
   output reg         irq
);
   ////////////////////////////////////////////////////////////////////
   // state registers
   reg [31:0] flags_ff;
   reg [31:0] nxt_flags;
   reg [31:0] ctrl_ff;
   reg [`EVT_WIDTH-1:0] evt_stat_ff;
   reg [`EVT_WIDTH-1:0] nxt_evt_stat;
   reg [`EVT_WIDTH-1:0] evt_mask_ff;
   reg [`EVT_WIDTH-1:0] evt_set;
   reg        maskable_interrupt_request_meta_ff;
   reg        maskable_interrupt_request_sync_ff;
   wire [31:0] res;
   wire        f_cf;
   wire        f_pf;
   wire        f_af;
   wire        f_zf;
   wire        f_sf;
   wire        f_of;
   wire        io_ok;
   wire        io_flt;
   wire        io_bmp;
   wire        if_ok;
   wire        io_privilege_level_ok;
   wire        apb_wr;
   wire [31:0] step;
   reg  [31:0] pop_mask;
   reg  [31:0] rdata;
   reg         addr_ok;

   ////////////////////////////////////////////////////////////////////
   // submodules
   arith_flag_unit u_arith (
      .sub                  (alu_sub),
      .width                (alu_width),
      .opa                  (alu_opa),
      .opb                  (alu_opb),
      .result               (res),
      .carry_out_flag       (f_cf),
      .low_byte_parity_flag (f_pf),
      .half_carry_flag      (f_af),
      .zero_flag            (f_zf),
      .sign_flag            (f_sf),
      .signed_overflow_flag (f_of)
   );

   io_priv_check u_priv (
      .current_privilege_level (ctrl_ff[`CTRL_CPL_HI:`CTRL_CPL_LO]),
      .io_privilege_level      (flags_ff[`BIT_IO_PRIVILEGE_LEVEL_HI:`BIT_IO_PRIVILEGE_LEVEL_LO]),
      .prot_mode               (ctrl_ff[`CTRL_PMODE]),
      .bitmap_en               (ctrl_ff[`CTRL_BITMAP]),
      .io_ok                   (io_ok),
      .io_fault                (io_flt),
      .io_bitmap               (io_bmp),
      .int_en_write_ok         (if_ok),
      .io_privilege_level_write_ok           (io_privilege_level_ok)
   );

   ////////////////////////////////////////////////////////////////////
   // flag register next state
   // a pop may only touch the bits its privilege allows
   always @* begin
      pop_mask = `FLAGS_IMPL;
      // RL3: gate int enable
      if (!if_ok)
         pop_mask[`BIT_INT_EN] = 1'b0;
      // RL2: gate io field
      if (!io_privilege_level_ok) begin
         pop_mask[`BIT_IO_PRIVILEGE_LEVEL_LO] = 1'b0;
         pop_mask[`BIT_IO_PRIVILEGE_LEVEL_HI] = 1'b0;
      end
   end

   // priority: task switch, then pop, then alu, then bus write
   always @* begin
      nxt_flags = flags_ff;
      if (task_switch) begin
         // RL2: task reload
         nxt_flags = (task_state_record & `FLAGS_IMPL) | `FLAGS_ONE;
      end else if (pop_flags_instruction || interrupt_return_instruction) begin
         nxt_flags = (flags_ff & ~pop_mask) | (pop_image & pop_mask);
      end else if (alu_valid) begin
         nxt_flags = flags_ff & ~`FLAGS_ARITH;
         nxt_flags[`BIT_CARRY]      = f_cf;
         nxt_flags[`BIT_PARITY]     = f_pf;
         nxt_flags[`BIT_HALF_CARRY] = f_af;
         nxt_flags[`BIT_ZERO]       = f_zf;
         nxt_flags[`BIT_SIGN]       = f_sf;
         nxt_flags[`BIT_OVERFLOW]   = f_of;
      end else if (apb_wr && paddr == `OFS_FLAGS) begin
         nxt_flags = (pwdata & `FLAGS_IMPL) | `FLAGS_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   assign apb_wr = psel & penable & pwrite;

   always @* begin
      addr_ok = 1'b1;
      rdata   = 32'h0000_0000;
      case (paddr)
         `OFS_FLAGS:     rdata = flags_ff;
         `OFS_CTRL:      rdata = ctrl_ff;
         `OFS_EVT_STAT:  rdata = {27'h000_0000, evt_stat_ff};
         `OFS_EVT_MASK:  rdata = {27'h000_0000, evt_mask_ff};
         `OFS_SAVED_IMG: rdata = stored_image;
         default:        addr_ok = 1'b0;
      endcase
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // answer in the cycle after setup, so access lasts one cycle
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (psel && !penable && !pwrite)
            prdata <= rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // events: set wins over write-one-to-clear
   always @* begin
      evt_set = {`EVT_WIDTH{1'b0}};
      evt_set[`EVT_IO_FAULT]  = io_req & io_flt;
      evt_set[`EVT_IO_BITMAP] = io_req & io_bmp;
      evt_set[`EVT_STEP_TRAP] = insn_done & flags_ff[`BIT_STEP];
      evt_set[`EVT_BRK_TRAP]  = insn_done & breakpoint_match;
      evt_set[`EVT_INT_TAKEN] = maskable_interrupt_request_sync_ff & flags_ff[`BIT_INT_EN];
      nxt_evt_stat = evt_stat_ff;
      if (apb_wr && paddr == `OFS_EVT_STAT)
         nxt_evt_stat = evt_stat_ff & ~pwdata[`EVT_WIDTH-1:0];
      nxt_evt_stat = nxt_evt_stat | evt_set;
   end

   ////////////////////////////////////////////////////////////////////
   // string step size, signed by direction
   // RL5: direction picks sign
   assign step = flags_ff[`BIT_DIR] ?
                 (32'h0000_0000 - {29'h0000_0000, string_size}) :
                 {29'h0000_0000, string_size};

   ////////////////////////////////////////////////////////////////////
   // sequential state
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         flags_ff     <= `FLAGS_RESET;
         ctrl_ff      <= `CTRL_RESET;
         evt_stat_ff  <= {`EVT_WIDTH{1'b0}};
         evt_mask_ff  <= {`EVT_WIDTH{1'b0}};
         maskable_interrupt_request_meta_ff <= 1'b0;
         maskable_interrupt_request_sync_ff <= 1'b0;
      end else begin
         flags_ff     <= nxt_flags;
         evt_stat_ff  <= nxt_evt_stat;
         // request pin is asynchronous to the core clock
         maskable_interrupt_request_meta_ff <= maskable_interrupt_request;
         maskable_interrupt_request_sync_ff <= maskable_interrupt_request_meta_ff;
         if (apb_wr && paddr == `OFS_CTRL)
            ctrl_ff <= {28'h000_0000, pwdata[3:0]};
         if (apb_wr && paddr == `OFS_EVT_MASK)
            evt_mask_ff <= pwdata[`EVT_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         alu_result                 <= 32'h0000_0000;
         stored_image               <= `FLAGS_RESET;
         io_grant                   <= 1'b0;
         io_fault13                 <= 1'b0;
         io_bitmap_check            <= 1'b0;
         source_index_register      <= 32'h0000_0000;
         destination_index_register <= 32'h0000_0000;
         interrupt_recognised       <= 1'b0;
         debug_trap                 <= 1'b0;
         processor_flags            <= `FLAGS_RESET;
         irq                        <= 1'b0;
      end else begin
         if (alu_valid)
            alu_result <= res;
         // RL13: stored image bits
         if (push_flags_instruction || interrupt_entry)
            stored_image <= (flags_ff & `FLAGS_IMPL) | `FLAGS_ONE;
         // RL1: i/o decision
         io_grant        <= io_req & io_ok;
         io_fault13      <= io_req & io_flt;
         io_bitmap_check <= io_req & io_bmp;
         // RL5: post step
         if (string_step) begin
            source_index_register      <= source_index_in + step;
            destination_index_register <= destination_index_in + step;
         end
         // RL6: enable gates request
         interrupt_recognised <= maskable_interrupt_request_sync_ff & flags_ff[`BIT_INT_EN];
         // RL7: step or breakpoint
         debug_trap <= insn_done &
                       (flags_ff[`BIT_STEP] | breakpoint_match);
         processor_flags <= nxt_flags;
         irq             <= |(nxt_evt_stat & evt_mask_ff);
      end
   end
endmodule

// >>> testbench/flag_rules_props.sv
// concurrent checks on the flag register block ports
`timescale 1ns/1ps
module flag_rules_props (
   // clock and reset
   input logic        mclk,
   input logic        arst_n,
   // pipeline requests
   input logic        alu_valid,
   input logic [1:0]  alu_width,
   input logic        pop_flags_instruction,
   input logic        interrupt_return_instruction,
   input logic        task_switch,
   input logic        push_flags_instruction,
   input logic        interrupt_entry,
   input logic        io_req,
   input logic        insn_done,
   input logic        breakpoint_match,
   // design answers
   input logic [31:0] alu_result,
   input logic [31:0] stored_image,
   input logic        io_grant,
   input logic        io_fault13,
   input logic        io_bitmap_check,
   input logic        debug_trap,
   input logic        interrupt_recognised,
   input logic [31:0] processor_flags
);
   logic       alu_only;
   logic [4:0] msb_ff;
   // pops and task switches outrank the adder, so judge lone adder ops only
   assign alu_only = alu_valid & ~task_switch & ~pop_flags_instruction
                     & ~interrupt_return_instruction;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         msb_ff <= 5'h07;
      else
         msb_ff <= (alu_width == 2'b00) ? 5'h07 :
                   (alu_width == 2'b01) ? 5'h0F : 5'h1F;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_io_one_answer: assert property (io_req |=>
      $onehot({io_grant, io_fault13, io_bitmap_check}))
      else $error("io request not answered once");
   a_io_no_answer: assert property (!io_req |=>
      !(io_grant | io_fault13 | io_bitmap_check))
      else $error("io answer without request");
   a_int_gated: assert property (interrupt_recognised |->
      $past(processor_flags[9])) else $error("interrupt taken while off");
   a_step_trap: assert property (insn_done && processor_flags[8] |=>
      debug_trap) else $error("single step trap missing");
   a_no_trap: assert property (insn_done && !processor_flags[8]
      && !breakpoint_match |=> !debug_trap) else $error("stray trap");
   a_store_fixed: assert property ((push_flags_instruction
      || interrupt_entry) |=> stored_image[1]
      && ((stored_image & 32'hFFF8_8028) == 32'h0000_0000))
      else $error("stored image fixed bits wrong");
   a_zero_flag: assert property (alu_only |=>
      processor_flags[6] == (alu_result == 32'h0000_0000))
      else $error("zero flag wrong");
   a_parity_flag: assert property (alu_only |=>
      processor_flags[2] == ~^alu_result[7:0]) else $error("parity wrong");
   a_sign_flag: assert property (alu_only |=>
      processor_flags[7] == alu_result[msb_ff]) else $error("sign wrong");
endmodule

// >>> testbench/exec_pipe_model.sv
// behavioural execution pipeline issuing adder, string and retire events
`timescale 1ns/1ps
module exec_pipe_model (
   // clock
   input  logic        mclk,
   // adder operation
   output logic        alu_valid,
   output logic        alu_sub,
   output logic [1:0]  alu_width,
   output logic [31:0] alu_opa,
   output logic [31:0] alu_opb,
   // string step and retire
   output logic        string_step,
   output logic [2:0]  string_size,
   output logic [31:0] source_index_in,
   output logic [31:0] destination_index_in,
   output logic        insn_done,
   output logic        breakpoint_match
);
   initial begin
      {alu_valid, alu_sub, alu_width, alu_opa, alu_opb} = '0;
      {string_step, string_size, source_index_in} = '0;
      {destination_index_in, insn_done, breakpoint_match} = '0;
   end
   // released operands are inverted so stale values never look valid
   task automatic alu(input logic s, input logic [1:0] w,
                      input logic [31:0] a, input logic [31:0] b);
      @(posedge mclk);
      alu_valid <= 1'b1;
      alu_sub <= s;
      alu_width <= w;
      alu_opa <= a;
      alu_opb <= b;
      @(posedge mclk);
      alu_valid <= 1'b0;
      alu_opa <= ~a;
      alu_opb <= ~b;
   endtask
   task automatic step(input logic [2:0] sz, input logic [31:0] si,
                       input logic [31:0] di);
      @(posedge mclk);
      string_step <= 1'b1;
      string_size <= sz;
      source_index_in <= si;
      destination_index_in <= di;
      @(posedge mclk);
      string_step <= 1'b0;
      source_index_in <= ~si;
      destination_index_in <= ~di;
   endtask
   task automatic done(input logic bp);
      @(posedge mclk);
      insn_done <= 1'b1;
      breakpoint_match <= bp;
      @(posedge mclk);
      insn_done <= 1'b0;
      breakpoint_match <= ~bp;
   endtask
endmodule

// >>> testbench/cpu_flag_state_logic_tb.sv
// self-checking bench for the flag register block
`timescale 1ns/1ps
`include "flag_logic_defines.vh"
module cpu_flag_state_logic_tb;
   logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        alu_valid, alu_sub, string_step, insn_done, breakpoint_match;
   logic        maskable_interrupt_request, io_grant, io_fault13, irq;
   logic        io_bitmap_check, interrupt_recognised, debug_trap, alu_seen;
   logic [1:0]  alu_width;
   logic [2:0]  string_size;
   logic [5:0]  pl;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, img, alu_opa, alu_opb, alu_result;
   logic [31:0] source_index_in, destination_index_in, stored_image;
   logic [31:0] source_index_register, destination_index_register;
   logic [31:0] processor_flags;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   integer      bad_count, n_compared, cyc, seed, i;
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;
   cpu_flag_state_logic DUT (
      .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .alu_valid, .alu_sub, .alu_width, .alu_opa,
      .alu_opb, .alu_result, .pop_flags_instruction(pl[0]),
      .interrupt_return_instruction(pl[1]), .pop_image(img),
      .task_switch(pl[2]), .task_state_record(img),
      .push_flags_instruction(pl[3]), .interrupt_entry(pl[5]),
      .stored_image, .io_req(pl[4]), .io_grant, .io_fault13,
      .io_bitmap_check, .string_step, .string_size, .source_index_in,
      .destination_index_in, .source_index_register,
      .destination_index_register, .maskable_interrupt_request,
      .insn_done, .breakpoint_match, .interrupt_recognised, .debug_trap,
      .processor_flags, .irq);
   exec_pipe_model pipe (
      .mclk, .alu_valid, .alu_sub, .alu_width, .alu_opa, .alu_opb,
      .string_step, .string_size, .source_index_in, .destination_index_in,
      .insn_done, .breakpoint_match);
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_compared = n_compared + 1;
      if (s !== x) begin
         bad_count = bad_count + 1;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   function automatic logic [63:0] model(input logic s, input logic [1:0] w,
                                         input logic [31:0] a, b);
      logic [31:0] mk, r, fl;
      logic [32:0] f;
      integer      m;
      m = (w == 2'b00) ? 7 : (w == 2'b01) ? 15 : 31;
      mk = (w == 2'b00) ? 32'h0000_00FF :
           (w == 2'b01) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      f = s ? {1'b0, a & mk} - {1'b0, b & mk} : {1'b0, a & mk} + {1'b0, b & mk};
      r = f[31:0] & mk;
      fl = 32'h0000_0000;
      fl[0] = f[m + 1];
      fl[2] = ~^r[7:0];
      fl[4] = a[4] ^ b[4] ^ r[4];
      fl[6] = (r == 32'h0000_0000);
      fl[7] = r[m];
      fl[11] = (a[m] == (b[m] ^ s)) && (r[m] != a[m]);
      return {r, fl};
   endfunction
   task automatic alu(input logic s, input logic [1:0] w,
                      input logic [31:0] a, input logic [31:0] b);
      exp_q.push_back(model(s, w, a, b));
      pipe.alu(s, w, a, b);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // answer and read data are taken at the edge that sees pready
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input integer n);
      @(posedge mclk);
      pl <= 6'h01 << n;
      @(posedge mclk);
      pl <= 6'h00;
      @(negedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (alu_seen) begin
         e = exp_q.pop_front();
         chk(alu_result, e[63:32]);
         chk(processor_flags & `FLAGS_ARITH, e[31:0]);
      end
      alu_seen <= alu_valid;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count = bad_count + 1;
         finish_test();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pl, img} = '0;
      {maskable_interrupt_request, alu_seen, arst_n} = '0;
      {bad_count, n_compared, cyc} = '0;
      seed = 32'hb0b4_3792;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      apb(1'b0, `OFS_FLAGS, 32'h0000_0000);
      chk(rd, `FLAGS_RESET);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk(err, 32'h0000_0001);
      alu(1'b0, `WID_BYTE, 32'h0000_007F, 32'h0000_0001);
      alu(1'b1, `WID_DWORD, 32'h0000_0000, 32'h0000_0001);
      alu(1'b0, `WID_WORD, 32'h0000_FFFF, 32'h0000_0001);
      for (i = 0; i < 48; i++)
         alu(1'($random(seed)), 2'(i % 3), $random(seed), $random(seed));
      for (i = 0; i < 2; i++) begin
         apb(1'b1, `OFS_FLAGS, 32'(i) << 10);
         pipe.step(3'h4, 32'h0000_0000, 32'hFFFF_FFFC);
         @(negedge mclk);
         chk(source_index_register, i ? 32'hFFFF_FFFC : 32'h0000_0004);
         chk(destination_index_register, i ? 32'hFFFF_FFF8 : '0);
      end
      apb(1'b1, `OFS_CTRL, 32'h0000_0007);
      apb(1'b1, `OFS_FLAGS, 32'h0000_0000);
      img = 32'h0000_3A00;
      pulse(0);
      chk(processor_flags, 32'h0000_0802);
      pulse(4);
      chk(io_fault13, 32'h0000_0001);
      apb(1'b1, `OFS_CTRL, 32'h0000_000F);
      pulse(4);
      chk(io_bitmap_check, 32'h0000_0001);
      img = 32'h0000_3000;
      pulse(2);
      chk(processor_flags, 32'h0000_3002);
      pulse(4);
      chk(io_grant, 32'h0000_0001);
      img = 32'h0000_0200;
      pulse(0);
      chk(processor_flags, 32'h0000_3202);
      apb(1'b1, `OFS_CTRL, 32'h0000_0004);
      img = 32'h0000_0000;
      pulse(1);
      chk(processor_flags, 32'h0000_0002);
      apb(1'b1, `OFS_FLAGS, 32'hFFFF_FFFF);
      pulse(3);
      chk(stored_image, 32'h0000_3FD7);
      pulse(5);
      chk(stored_image, 32'h0000_3FD7);
      apb(1'b0, `OFS_EVT_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      apb(1'b1, `OFS_EVT_MASK, 32'h0000_0002);
      repeat (2) @(negedge mclk);
      chk(irq, 32'h0000_0001);
      apb(1'b1, `OFS_EVT_STAT, 32'h0000_0002);
      repeat (2) @(negedge mclk);
      chk(irq, 32'h0000_0000);
      @(posedge mclk);
      maskable_interrupt_request <= 1'b1;
      repeat (4) @(negedge mclk);
      chk(interrupt_recognised, 32'h0000_0001);
      for (i = 0; i < 3; i++) begin
         apb(1'b1, `OFS_FLAGS, 32'(i == 2) << 8);
         if (i == 0) begin
            repeat (2) @(negedge mclk);
            chk(interrupt_recognised, 32'h0000_0000);
         end
         pipe.done(i == 1);
         @(negedge mclk);
         chk(debug_trap, 32'(i != 0));
      end
      finish_test();
   end
endmodule
bind cpu_flag_state_logic flag_rules_props u_props (
   .mclk, .arst_n, .alu_valid, .alu_width, .pop_flags_instruction,
   .interrupt_return_instruction, .task_switch, .push_flags_instruction,
   .interrupt_entry, .io_req, .insn_done, .breakpoint_match, .alu_result,
   .stored_image, .io_grant, .io_fault13, .io_bitmap_check, .debug_trap,
   .interrupt_recognised, .processor_flags);
